// ### common/tuner_ctrl_pkg.sv
// Purpose: shared constants for the two-wire tuner control port
// Assumes: 50 MHz mclk, host-made serial clock
// Notes: addresses and mode codes used by both ends
package tuner_ctrl_pkg;
  localparam logic [6:0] ADDR_SEL_LOW = 7'h11;  // 0010001b
  localparam logic [6:0] ADDR_SEL_HIGH = 7'h63; // 1100011b
  localparam int MAX_WRITE_BYTES = 8;
  localparam int MAX_READ_BYTES = 16;
  localparam int CLK_PERIOD_NS = 20;
  localparam int START_GUARD_NS = 300;
  localparam int START_GUARD_CYC = (START_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_HALF_CYC = 4; // Host serial clock half period in mclk cycles
  localparam int CTS_BIT = 7;
  typedef enum logic [1:0] {
    MODE_THREE_WIRE = 2'b00,
    MODE_UNUSED = 2'b01,
    MODE_TWO_WIRE = 2'b10,
    MODE_SPI = 2'b11
  } bus_mode_t;
endpackage

// ### common/tuner_link_if.sv
// Purpose: pins between host and tuner control port
// Assumes: open-drain data, host-driven clock
// Notes: wire levels resolved here from enables
`timescale 1ns/1ps
interface tuner_link_if;
  logic reset_pin;
  logic serial_clock_pin;
  logic serial_data_pin;
  logic sda_dev_oe;
  logic sda_host_oe;
  logic strap_a_dev_o;
  logic strap_a_dev_oe;
  logic strap_b_dev_o;
  logic strap_b_dev_oe;
  logic strap_a_host_o;
  logic strap_a_host_oe;
  logic strap_b_host_o;
  logic strap_b_host_oe;
  logic mode_strap_a;
  logic mode_strap_b;
  // Open drain line: low if anyone drives, otherwise pulled up
  assign serial_data_pin = ~(sda_dev_oe | sda_host_oe);
  // Straps: pull-up on a only while reset is low; b pulled down at all times
  assign mode_strap_a = strap_a_host_oe ? strap_a_host_o :
                        strap_a_dev_oe ? strap_a_dev_o : ~reset_pin ? 1'b1 : 1'b0;
  assign mode_strap_b = strap_b_host_oe ? strap_b_host_o :
                        strap_b_dev_oe ? strap_b_dev_o : 1'b0;
  modport device (
    input reset_pin, serial_clock_pin, serial_data_pin, mode_strap_a, mode_strap_b,
    output sda_dev_oe, strap_a_dev_o, strap_a_dev_oe, strap_b_dev_o, strap_b_dev_oe
  );
  modport host (
    input serial_data_pin, mode_strap_a, mode_strap_b,
    output reset_pin, serial_clock_pin, sda_host_oe,
    output strap_a_host_o, strap_a_host_oe, strap_b_host_o, strap_b_host_oe
  );
endinterface

// ### rtl/tuner_ctrl_device.sv
// Purpose: device end of the two-wire control port
// Assumes: pins arrive asynchronously to mclk
// Notes: commands go out as byte pulses, responses come from a user array
// Operation
// - Latch bus mode from straps at reset release
// - Pull strap a up, b down in reset
// - Host drives only straps departing from pulls
// - Straps become outputs after reset release
// - Host reads status until clear-to-send high
// - Clock high across reset release, guard START
// - START is data falling while clock high
// - Eight-bit control word, MSB first, rising edges
// - Acknowledge matching control word from falling edge
// - Address chosen by address select pin level
// - Host writes at most eight bytes
// - Acknowledge each write byte for one cycle
// - Read bytes change only on falling edges
// - Missing host acknowledge ends read, releases line
// - At most sixteen response bytes per read
// - STOP is data rising while clock high
// - Host keeps bus quiet during seek or tune
// - Reset pin active low, disables the bus
`timescale 1ns/1ps
module tuner_ctrl_device
  import tuner_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  tuner_link_if.device link,
  input wire logic address_select_pin,
  input wire logic [1:0] gpo_level,
  input wire logic [1:0] gpo_enable,
  input wire logic [7:0] resp_data [MAX_READ_BYTES],
  output tuner_ctrl_pkg::bus_mode_t bus_mode,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic [2:0] cmd_index,
  output logic cmd_done
);
  import tuner_ctrl_pkg::*;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_RACK,
    ST_IGNORE
  } dev_state_t;

  logic [2:0] rst_sync_reg;
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] sel_sync_reg;
  logic [2:0] strap_a_sync_reg;
  logic [2:0] strap_b_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic in_reset;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  dev_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [4:0] byte_cnt_reg;
  logic ack_phase_reg;
  logic ack_drive_reg;
  logic sda_out_low_reg;
  logic [6:0] my_addr;

  // Synchronisers on every pin: two flops, three for reset and the straps
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 3'h0;
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      sel_sync_reg <= 2'h0;
      strap_a_sync_reg <= 3'h7;
      strap_b_sync_reg <= 3'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[1:0], link.reset_pin};
      scl_sync_reg <= {scl_sync_reg[0], link.serial_clock_pin};
      sda_sync_reg <= {sda_sync_reg[0], link.serial_data_pin};
      sel_sync_reg <= {sel_sync_reg[0], address_select_pin};
      strap_a_sync_reg <= {strap_a_sync_reg[1:0], link.mode_strap_a};
      strap_b_sync_reg <= {strap_b_sync_reg[1:0], link.mode_strap_b};
    end
  end

  assign in_reset = ~rst_sync_reg[1];

  // Edge history taken from synchronised levels only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  assign scl_rise = scl_sync_reg[1] & ~scl_prev_reg;
  assign scl_fall = ~scl_sync_reg[1] & scl_prev_reg;
  assign start_cond = scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1];
  assign stop_cond = scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1];
  assign my_addr = sel_sync_reg[1] ? ADDR_SEL_HIGH : ADDR_SEL_LOW;

  // Mode caught on the synchronised reset rise, held until next reset
  // Straps lose their pulls as reset rises, so the strap sample is taken
  // one stage later, from the last sample with reset still low
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus_mode <= MODE_TWO_WIRE;
    end else if (rst_sync_reg[1] & ~rst_sync_reg[2]) begin
      bus_mode <= bus_mode_t'({strap_a_sync_reg[2], strap_b_sync_reg[2]});
    end
  end

  // Pulls live in the interface; straps drive only out of reset
  assign link.strap_a_dev_oe = ~in_reset & gpo_enable[0];
  assign link.strap_b_dev_oe = ~in_reset & gpo_enable[1];
  assign link.strap_a_dev_o = gpo_level[0];
  assign link.strap_b_dev_o = gpo_level[1];
  assign link.sda_dev_oe = sda_out_low_reg;

  // Protocol engine; reset and non-two-wire mode win first, then STOP, then START
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      byte_cnt_reg <= 5'h00;
      ack_phase_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
    end else if (in_reset || bus_mode != MODE_TWO_WIRE) begin
      state_reg <= ST_IDLE;
      ack_phase_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
    end else if (stop_cond) begin
      state_reg <= ST_IDLE;
      ack_phase_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
    end else if (start_cond) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      byte_cnt_reg <= 5'h00;
      ack_phase_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_WDATA: begin
          if (!ack_phase_reg && scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (!ack_phase_reg && scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == ST_ADDR && shift_reg[7:1] != my_addr) begin
              state_reg <= ST_IGNORE;
            end else begin
              ack_phase_reg <= 1'b1;
              ack_drive_reg <= 1'b1;
            end
          end else if (ack_phase_reg && scl_fall) begin
            ack_phase_reg <= 1'b0;
            ack_drive_reg <= 1'b0;
            if (state_reg == ST_ADDR) begin
              if (shift_reg[0]) begin
                state_reg <= ST_RDATA;
                shift_reg <= resp_data[0];
                byte_cnt_reg <= 5'h01;
              end else begin
                state_reg <= ST_WDATA;
              end
            end else if (byte_cnt_reg < 5'(MAX_WRITE_BYTES)) begin
              byte_cnt_reg <= byte_cnt_reg + 5'h01;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_RACK;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              shift_reg <= {shift_reg[6:0], 1'b1};
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_sync_reg[1] || byte_cnt_reg == 5'(MAX_READ_BYTES)) begin
              state_reg <= ST_IGNORE;
            end else begin
              shift_reg <= resp_data[byte_cnt_reg[3:0]];
              byte_cnt_reg <= byte_cnt_reg + 5'h01;
            end
          end else if (scl_fall) begin
            state_reg <= ST_RDATA; // Next byte starts on this falling edge
          end
        end
        ST_IDLE, ST_IGNORE: begin
          bit_cnt_reg <= 4'h0;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Line driven low for acks and for zero read bits
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sda_out_low_reg <= 1'b0;
    end else if (state_reg == ST_RDATA) begin
      sda_out_low_reg <= ~shift_reg[7];
    end else begin
      sda_out_low_reg <= ack_drive_reg;
    end
  end

  // Up to eight write bytes handed to the user, one pulse each
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_valid <= 1'b0;
      cmd_byte <= 8'h00;
      cmd_index <= 3'h0;
      cmd_done <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      cmd_done <= 1'b0;
      if (state_reg == ST_WDATA && !ack_phase_reg && scl_fall && bit_cnt_reg == 4'h8
          && byte_cnt_reg < 5'(MAX_WRITE_BYTES) && !start_cond && !stop_cond) begin
        cmd_valid <= 1'b1;
        cmd_byte <= shift_reg;
        cmd_index <= byte_cnt_reg[2:0];
      end
      if (stop_cond && state_reg == ST_WDATA && byte_cnt_reg != 5'h00) begin
        cmd_done <= 1'b1;
      end
    end
  end
endmodule

// ### rtl/tuner_ctrl_host.sv
// Purpose: host end driving the two-wire control port
// Assumes: serial clock made by divider from mclk
// Notes: one transaction per go pulse; caller polls status itself
`timescale 1ns/1ps
module tuner_ctrl_host
  import tuner_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  tuner_link_if.host link,
  input wire logic dev_reset_n,
  input wire tuner_ctrl_pkg::bus_mode_t mode_sel,
  input wire logic address_high,
  input wire logic go,
  input wire logic rd_not_wr,
  input wire logic [4:0] nbytes,
  input wire logic [7:0] wr_data [MAX_WRITE_BYTES],
  output logic busy,
  output logic done,
  output logic nack,
  output logic [7:0] rd_data [MAX_READ_BYTES],
  output logic cts_ok
);
  import tuner_ctrl_pkg::*;

  typedef enum {
    H_IDLE,
    H_START,
    H_BIT_LO,
    H_BIT_HI,
    H_STOP_LO,
    H_STOP_HI
  } host_state_t;

  host_state_t state_reg;
  logic [1:0] sda_sync_reg;
  logic [2:0] div_reg;
  logic tick;
  logic scl_reg;
  logic sda_low_reg;
  logic [8:0] shift_reg;
  logic [3:0] bit_reg;
  logic [4:0] byte_reg;
  logic addr_phase_reg;
  logic rd_reg;
  logic [4:0] count_reg;
  logic [4:0] rd_idx;

  assign tick = (div_reg == 3'(SCL_HALF_CYC - 1));
  assign link.reset_pin = dev_reset_n;
  assign link.serial_clock_pin = scl_reg;
  assign link.sda_host_oe = sda_low_reg;
  // Straps forced only where they differ from the pulls
  assign link.strap_a_host_oe = ~dev_reset_n & (mode_sel == MODE_THREE_WIRE);
  assign link.strap_a_host_o = 1'b0;
  assign link.strap_b_host_oe = ~dev_reset_n & (mode_sel == MODE_SPI);
  assign link.strap_b_host_o = 1'b1;
  assign busy = (state_reg != H_IDLE);
  assign cts_ok = rd_data[0][CTS_BIT];
  assign rd_idx = byte_reg - 5'h01;

  // Data line synchroniser
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sda_sync_reg <= 2'h3;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], link.serial_data_pin};
    end
  end

  // Half-bit enable divider
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 3'h0;
    end else if (state_reg == H_IDLE || tick) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end

  // Bit sequencer; ninth bit of each byte is the ack slot
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= H_IDLE;
      scl_reg <= 1'b1;
      sda_low_reg <= 1'b0;
      shift_reg <= 9'h000;
      bit_reg <= 4'h0;
      byte_reg <= 5'h00;
      addr_phase_reg <= 1'b0;
      rd_reg <= 1'b0;
      count_reg <= 5'h00;
      done <= 1'b0;
      nack <= 1'b0;
      for (int i = 0; i < MAX_READ_BYTES; i++) begin
        rd_data[i] <= 8'h00;
      end
    end else begin
      done <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          scl_reg <= 1'b1;
          sda_low_reg <= 1'b0;
          if (go && dev_reset_n) begin
            rd_reg <= rd_not_wr;
            count_reg <= rd_not_wr ? ((nbytes > 5'(MAX_READ_BYTES)) ? 5'(MAX_READ_BYTES) : nbytes)
                       : ((nbytes > 5'(MAX_WRITE_BYTES)) ? 5'(MAX_WRITE_BYTES) : nbytes);
            shift_reg <= {address_high ? ADDR_SEL_HIGH : ADDR_SEL_LOW, rd_not_wr, 1'b1};
            addr_phase_reg <= 1'b1;
            byte_reg <= 5'h00;
            bit_reg <= 4'h0;
            nack <= 1'b0;
            sda_low_reg <= 1'b1; // START: data falls, clock high
            state_reg <= H_START;
          end
        end
        H_START: if (tick) begin
          scl_reg <= 1'b0;
          state_reg <= H_BIT_LO;
        end
        H_BIT_LO: if (tick) begin
          // Data set on the same mclk edge that raises the clock
          sda_low_reg <= ~shift_reg[8];
          scl_reg <= 1'b1;
          state_reg <= H_BIT_HI;
        end
        H_BIT_HI: if (tick) begin
          scl_reg <= 1'b0;
          shift_reg <= {shift_reg[7:0], sda_sync_reg[1]};
          if (bit_reg == 4'h8) begin
            bit_reg <= 4'h0;
            if ((addr_phase_reg || !rd_reg) && sda_sync_reg[1]) begin
              nack <= 1'b1;
              state_reg <= H_STOP_LO;
            end else if (!addr_phase_reg && rd_reg) begin
              rd_data[rd_idx[3:0]] <= shift_reg[7:0];
              state_reg <= (byte_reg == count_reg) ? H_STOP_LO : H_BIT_LO;
            end else if (byte_reg == count_reg) begin
              state_reg <= H_STOP_LO;
            end else begin
              state_reg <= H_BIT_LO;
            end
            addr_phase_reg <= 1'b0;
            byte_reg <= byte_reg + 5'h01;
            // Next byte: write data, or release and ack unless last read
            if (rd_reg) begin
              shift_reg <= {8'hff, (byte_reg + 5'h01 == count_reg)};
            end else begin
              shift_reg <= {wr_data[byte_reg[2:0]], 1'b1};
            end
          end else begin
            bit_reg <= bit_reg + 4'h1;
            state_reg <= H_BIT_LO;
          end
        end
        H_STOP_LO: if (tick) begin
          sda_low_reg <= 1'b1;
          scl_reg <= 1'b1;
          state_reg <= H_STOP_HI;
        end
        H_STOP_HI: if (tick) begin
          sda_low_reg <= 1'b0; // STOP: data rises, clock high
          done <= 1'b1;
          state_reg <= H_IDLE;
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end
endmodule

// ### tb/tuner_link_sva.sv
// Purpose: protocol checks on the two-wire link between host and device
// Assumes: host moves the wire only just after mclk edges
// Notes: frame tracking here samples the wire with no synchroniser
`timescale 1ns/1ps
module tuner_link_sva
  import tuner_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic address_select_pin,
  input wire logic reset_pin,
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin,
  input wire logic sda_dev_oe,
  input wire logic strap_a_dev_oe,
  input wire logic strap_b_dev_oe
);
  logic scl_q, sda_q, matched_reg, rd_reg, quiet_reg, idle_reg;
  logic [7:0] slot_reg;
  logic [7:0] ctrl_reg;
  logic rise, start, stop;
  logic [6:0] own_addr;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Wire events seen by comparing with the previous sample
  assign rise = serial_clock_pin && !scl_q;
  assign start = serial_clock_pin && scl_q && sda_q && !serial_data_pin;
  assign stop = serial_clock_pin && scl_q && !sda_q && serial_data_pin;
  assign own_addr = address_select_pin ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
  // Previous wire levels
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= serial_clock_pin;
      sda_q <= serial_data_pin;
    end
  end
  // Bit slot count and control word of the current frame
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      slot_reg <= 8'h00;
      ctrl_reg <= 8'h00;
    end else if (start) begin
      slot_reg <= 8'h00;
    end else if (rise && slot_reg != 8'hff) begin
      slot_reg <= slot_reg + 8'h01;
      if (slot_reg < 8'h08) ctrl_reg <= {ctrl_reg[6:0], serial_data_pin};
    end
  end
  // Frame state: idle between STOP and START, quiet after mismatch or read nack
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idle_reg <= 1'b1;
      quiet_reg <= 1'b0;
      matched_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else if (start) begin
      idle_reg <= 1'b0;
      quiet_reg <= 1'b0;
    end else if (stop) begin
      idle_reg <= 1'b1;
    end else if (rise && slot_reg == 8'h08) begin
      matched_reg <= ctrl_reg[7:1] == own_addr;
      rd_reg <= ctrl_reg[0];
      quiet_reg <= ctrl_reg[7:1] != own_addr;
    end else if (rise && rd_reg && slot_reg > 8'h08 && slot_reg % 9 == 8 && serial_data_pin) begin
      quiet_reg <= 1'b1;
    end
  end
  sequence s_reset_held;
    (!reset_pin) [*4];
  endsequence
  sequence s_high_settled;
    serial_clock_pin [*3];
  endsequence
  sequence s_ack_slot;
    rise && !idle_reg && slot_reg > 8'h08 && slot_reg % 9 == 8;
  endsequence
  a_reset_bus_off: assert property (s_reset_held |-> !sda_dev_oe && !strap_a_dev_oe && !strap_b_dev_oe)
    else $error("device drives pins while held in reset");
  a_data_hold_high: assert property (s_high_settled |-> $stable(sda_dev_oe))
    else $error("device data changed while serial clock high");
  a_ctrl_ack_addr: assert property (rise && !idle_reg && slot_reg == 8'h08 |->
    serial_data_pin == (ctrl_reg[7:1] != own_addr))
    else $error("control word acknowledge does not follow address");
  a_write_byte_ack: assert property (s_ack_slot and (matched_reg && !rd_reg) |-> !serial_data_pin)
    else $error("write byte not acknowledged");
  a_write_bits_free: assert property (rise && !idle_reg &&
    (slot_reg < 8'h08 || (matched_reg && !rd_reg && slot_reg % 9 != 8)) |-> !sda_dev_oe)
    else $error("device drives data during host bits");
  a_quiet_released: assert property (quiet_reg |-> !sda_dev_oe)
    else $error("device drives after mismatch or read nack");
  a_read_count_max: assert property (!idle_reg && matched_reg && rd_reg && slot_reg > 8'd152
    |-> !sda_dev_oe)
    else $error("device drives beyond sixteen read bytes");
  a_idle_released: assert property (idle_reg |-> !sda_dev_oe)
    else $error("device drives data after stop");
endmodule

// ### tb/tb_tuner_two_wire_control_port.sv
// Purpose: end to end test of host and device over the two-wire link
// Assumes: host divides mclk for the serial clock; straps released after reset
// Notes: expectations come from the bench's own byte tables
`timescale 1ns/1ps
module tb_tuner_two_wire_control_port;
  import tuner_ctrl_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic address_select_pin = 1'b0;
  logic [1:0] gpo_level = 2'b00;
  logic [1:0] gpo_enable = 2'b00;
  logic [7:0] resp_data [MAX_READ_BYTES];
  logic [7:0] wr_data [MAX_WRITE_BYTES];
  logic [7:0] rd_data [MAX_READ_BYTES];
  logic [7:0] got [MAX_WRITE_BYTES];
  bus_mode_t bus_mode;
  bus_mode_t mode_sel = MODE_TWO_WIRE;
  bus_mode_t modes [3] = '{MODE_SPI, MODE_THREE_WIRE, MODE_TWO_WIRE};
  logic cmd_valid, cmd_done, busy, done, nack, cts_ok;
  logic [7:0] cmd_byte;
  logic [2:0] cmd_index;
  logic dev_reset_n = 1'b0;
  logic address_high = 1'b0;
  logic go = 1'b0;
  logic rd_not_wr = 1'b0;
  logic [4:0] nbytes = 5'h01;
  int ncmd = 0;
  int ndone = 0;
  int mismatches = 0;
  int comparisons = 0;
  tuner_link_if link ();
  tuner_ctrl_device tuner_ctrl_device_i (.mclk(mclk), .rstn(rstn), .link(link.device),
    .address_select_pin(address_select_pin), .gpo_level(gpo_level), .gpo_enable(gpo_enable),
    .resp_data(resp_data), .bus_mode(bus_mode), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .cmd_index(cmd_index), .cmd_done(cmd_done));
  tuner_ctrl_host tuner_ctrl_host_i (.mclk(mclk), .rstn(rstn), .link(link.host),
    .dev_reset_n(dev_reset_n), .mode_sel(mode_sel), .address_high(address_high), .go(go),
    .rd_not_wr(rd_not_wr), .nbytes(nbytes), .wr_data(wr_data), .busy(busy), .done(done),
    .nack(nack), .rd_data(rd_data), .cts_ok(cts_ok));
  tuner_link_sva tuner_link_sva_i (.mclk(mclk), .rstn(rstn),
    .address_select_pin(address_select_pin), .reset_pin(link.reset_pin),
    .serial_clock_pin(link.serial_clock_pin), .serial_data_pin(link.serial_data_pin),
    .sda_dev_oe(link.sda_dev_oe), .strap_a_dev_oe(link.strap_a_dev_oe),
    .strap_b_dev_oe(link.strap_b_dev_oe));
  // Free running system clock
  always #10 mclk = ~mclk;
  // Collect forwarded command bytes; pre-edge values, like a flop would see
  always @(posedge mclk) begin
    if (cmd_valid === 1'b1) begin
      got[cmd_index] = cmd_byte;
      ncmd++;
    end
    if (cmd_done === 1'b1) ndone++;
  end
  task automatic check8(input logic [7:0] act, input logic [7:0] exp);
    comparisons++;
    if (act !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic check1(input logic act, input logic exp);
    comparisons++;
    if (act !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Device reset with a strap request; long wait keeps START clear of the release
  task automatic dev_reset(input bus_mode_t m);
    @(posedge mclk);
    dev_reset_n <= 1'b0;
    mode_sel <= m;
    repeat (10) @(posedge mclk);
    dev_reset_n <= 1'b1;
    repeat (START_GUARD_CYC + 20) @(posedge mclk);
  endtask
  // One transaction: go pulse, then a bounded wait for done
  task automatic xfer(input logic rd, input logic [4:0] n);
    int t;
    t = 0;
    ncmd = 0;
    ndone = 0;
    @(posedge mclk);
    rd_not_wr <= rd;
    nbytes <= n;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(negedge mclk);
    check1(busy, 1'b1);
    while (done !== 1'b1 && t < 4000) begin
      @(negedge mclk);
      t++;
    end
    if (t >= 4000) mismatches++;
    // Device sees the STOP three cycles after the wire moves
    repeat (6) @(posedge mclk);
  endtask
  // Watchdog sized well above the whole sequence
  initial begin
    repeat (30000) @(posedge mclk);
    mismatches++;
    close_out();
  end
  initial begin
    for (int i = 0; i < MAX_WRITE_BYTES; i++) wr_data[i] = 8'h5a ^ 8'(i * 37);
    for (int i = 0; i < MAX_READ_BYTES; i++) resp_data[i] = 8'h3c ^ 8'(i * 17);
    resp_data[0] = 8'h81;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    // Three strap codes, all but the unused one, ending in two-wire
    for (int m = 0; m < 3; m++) begin
      dev_reset(modes[m]);
      check8({6'h00, bus_mode}, {6'h00, modes[m]});
    end
    // Straps as outputs after release
    gpo_enable <= 2'b11;
    gpo_level <= 2'b11;
    repeat (5) @(posedge mclk);
    check1(link.mode_strap_a & link.mode_strap_b, 1'b1);
    gpo_level <= 2'b00;
    repeat (5) @(posedge mclk);
    check1(link.mode_strap_a | link.mode_strap_b, 1'b0);
    gpo_enable <= 2'b00;
    // Full eight byte write
    xfer(1'b0, 5'd8);
    check1(nack, 1'b0);
    check8(8'(ncmd), 8'd8);
    for (int i = 0; i < MAX_WRITE_BYTES; i++) check8(got[i], wr_data[i]);
    check8(8'(ndone), 8'd1);
    // Full sixteen byte read, back to back
    xfer(1'b1, 5'd16);
    for (int i = 0; i < MAX_READ_BYTES; i++) check8(rd_data[i], resp_data[i]);
    check1(cts_ok, 1'b1);
    // Short read ended by host nack, then a new read restarts at status
    // Fresh response bytes, so stale read data cannot pass
    resp_data[2] <= 8'ha5;
    xfer(1'b1, 5'd3);
    check8(rd_data[2], resp_data[2]);
    resp_data[0] <= 8'hc4;
    xfer(1'b1, 5'd1);
    check8(rd_data[0], resp_data[0]);
    // Wrong address refused, then address select moved to match
    address_high <= 1'b1;
    xfer(1'b0, 5'd2);
    check1(nack, 1'b1);
    check8(8'(ncmd), 8'd0);
    address_select_pin <= 1'b1;
    repeat (8) @(posedge mclk);
    xfer(1'b0, 5'd2);
    check1(nack, 1'b0);
    check8(8'(ncmd), 8'd2);
    address_high <= 1'b0;
    xfer(1'b1, 5'd1);
    check1(nack, 1'b1);
    close_out();
  end
endmodule
